//--- hdl/src_pkg.sv
`default_nettype none
package src_pkg;
	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CAUSE = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_OSC = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_ACTIVE = 12'h014;

	// ----------------------------------------------------------------
	// reset cause bit positions
	// ----------------------------------------------------------------
	localparam int NCAUSE = 10;
	localparam int NPIN = 3;
	localparam int NLOGIC = 7;
	localparam int B_POWER_ON = 0;
	localparam int B_BROWN_OUT = 1;
	localparam int B_EXT_CLEAR = 2;
	localparam int B_RESET_INSTR = 3;
	localparam int B_WATCHDOG = 4;
	localparam int B_CFG_MISMATCH = 5;
	localparam int B_TRAP_CONFLICT = 6;
	localparam int B_ILL_OPCODE = 7;
	localparam int B_UNINIT_WREG = 8;
	localparam int B_SECURITY = 9;

	// reset values
	localparam logic [REG_W-1:0] CAUSE_POWER_ON_VAL = 16'h0003;
	localparam logic [REG_W-1:0] OSC_RST_VAL = 16'h0000;
	localparam logic [NCAUSE-1:0] IRQ_EN_RST_VAL = 10'h000;

	// new oscillator field inside oscillator control
	localparam int NEW_OSCILLATOR_FIELD_LSB = 8;
	localparam int NEW_OSCILLATOR_FIELD_W = 3;
endpackage
`default_nettype wire

//--- hdl/src_cause_if.sv
`timescale 1ns/1ps
`default_nettype none
// one group of reset causes between the combiner and its conditioning stage
interface src_cause_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] level;
	logic [W-1:0] rise;
	modport det (input raw, output level, output rise);
	modport user (output raw, input level, input rise);
endinterface
`default_nettype wire

//--- hdl/src_cause_cond.sv
`timescale 1ns/1ps
`default_nettype none
// conditions one group of cause inputs: optional two-stage sync and rise detect
module src_cause_cond #(
	parameter int W = 1,
	parameter bit SYNC = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	src_cause_if.det c
);
	logic [W-1:0] lvl_q;
	logic [W-1:0] prev_q;

	generate
		if (SYNC) begin : g_sync
			logic [W-1:0] meta_q;
			// first stage is read only by the second stage
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_q <= '0;
					lvl_q <= '0;
				end else if (ce) begin
					meta_q <= c.raw;
					lvl_q <= meta_q;
				end
			end
		end else begin : g_direct
			// same-clock sources are used as they come
			always_comb begin
				lvl_q = c.raw;
			end
		end
	endgenerate

	// previous level for rise detection
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_q <= '0;
		end else if (ce) begin
			prev_q <= lvl_q;
		end
	end

	assign c.level = lvl_q;
	assign c.rise = lvl_q & ~prev_q & {W{ce}};
endmodule
`default_nettype wire

//--- hdl/src_reset_combiner.sv
`timescale 1ns/1ps
`default_nettype none
module src_reset_combiner (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic POWER_ON_RESET,
	input wire logic BROWN_OUT_RESET,
	input wire logic EXTERNAL_CLEAR_PIN_RESET_N,
	input wire logic RESET_INSTRUCTION_CAUSE,
	input wire logic WATCHDOG_TIMEOUT_RESET,
	input wire logic CONFIGURATION_MISMATCH_RESET,
	input wire logic TRAP_CONFLICT_RESET,
	input wire logic ILLEGAL_OPCODE_RESET,
	input wire logic UNINIT_WREG_RESET,
	input wire logic SECURITY_RESET,
	input wire logic [src_pkg::NEW_OSCILLATOR_FIELD_W-1:0] BOOT_OSCILLATOR_CHOICE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [src_pkg::ADDR_W-1:0] PADDR,
	input wire logic [src_pkg::DATA_W-1:0] PWDATA,
	output var logic [src_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output var logic MASTER_RESET_SIGNAL,
	output logic [src_pkg::NEW_OSCILLATOR_FIELD_W-1:0] NEW_OSCILLATOR_FIELD,
	output var logic IRQ
);
	import src_pkg::*;

	// ----------------------------------------------------------------
	// cause conditioning
	// ----------------------------------------------------------------
	src_cause_if #(.W(NPIN)) pin_c ();
	src_cause_if #(.W(NLOGIC)) cpu_c ();

	logic [NCAUSE-1:0] cause_act;
	logic [NCAUSE-1:0] cause_rise;
	logic [REG_W-1:0] cause_q;
	logic [REG_W-1:0] cause_d;
	logic [REG_W-1:0] osc_q;
	logic [NCAUSE-1:0] ist_q;
	logic [NCAUSE-1:0] ien_q;
	logic any_cause;
	logic setup;
	logic wr_acc;
	logic mapped;
	logic wr_cause;
	logic [REG_W-1:0] wr_val;

	// pin causes cross from outside the clock domain; the clear pin is active low
	assign pin_c.raw[B_POWER_ON] = POWER_ON_RESET;
	assign pin_c.raw[B_BROWN_OUT] = BROWN_OUT_RESET;
	assign pin_c.raw[B_EXT_CLEAR] = ~EXTERNAL_CLEAR_PIN_RESET_N;

	// cpu and watchdog causes come from logic on this clock
	assign cpu_c.raw = {SECURITY_RESET, UNINIT_WREG_RESET, ILLEGAL_OPCODE_RESET,
		TRAP_CONFLICT_RESET, CONFIGURATION_MISMATCH_RESET,
		WATCHDOG_TIMEOUT_RESET, RESET_INSTRUCTION_CAUSE};

	src_cause_cond #(.W(NPIN), .SYNC(1'b1)) u_pin (
		.clk(CLOCK),
		.rst(SYS_RST),
		.ce(CLK_EN),
		.c(pin_c)
	);

	src_cause_cond #(.W(NLOGIC), .SYNC(1'b0)) u_cpu (
		.clk(CLOCK),
		.rst(SYS_RST),
		.ce(CLK_EN),
		.c(cpu_c)
	);

	// every cause lands in its own bit position
	assign cause_act = {cpu_c.level, pin_c.level};
	assign cause_rise = {cpu_c.rise, pin_c.rise};
	assign any_cause = |cause_act;

	// ----------------------------------------------------------------
	// master reset
	// ----------------------------------------------------------------
	// the cause flags never feed this; only live cause inputs do
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			MASTER_RESET_SIGNAL <= 1'b1;
		end else if (CLK_EN) begin
			MASTER_RESET_SIGNAL <= any_cause;
		end
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign setup = PSEL & ~PENABLE;
	assign wr_acc = PSEL & PENABLE & PWRITE & CLK_EN;
	assign wr_val = PWDATA[REG_W-1:0];
	assign PREADY = 1'b1;
	assign wr_cause = wr_acc & (PADDR == OFF_CAUSE);

	// address decode for the error answer
	always_comb begin
		if (PADDR == OFF_CAUSE) begin
			mapped = 1'b1;
		end else if (PADDR == OFF_OSC) begin
			mapped = 1'b1;
		end else if (PADDR == OFF_IRQ_STAT) begin
			mapped = 1'b1;
		end else if (PADDR == OFF_IRQ_CLR) begin
			mapped = 1'b1;
		end else if (PADDR == OFF_IRQ_EN) begin
			mapped = 1'b1;
		end else if (PADDR == OFF_ACTIVE) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end
	// error only in the access phase, so a setup cycle never shows it
	assign PSLVERR = PSEL & PENABLE & ~mapped;

	// read data captured in the setup cycle, valid through the access phase
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			PRDATA <= '0;
		end else if (CLK_EN && setup && !PWRITE) begin
			if (PADDR == OFF_CAUSE) begin
				PRDATA <= DATA_W'(cause_q);
			end else if (PADDR == OFF_OSC) begin
				PRDATA <= DATA_W'(osc_q);
			end else if (PADDR == OFF_IRQ_STAT) begin
				PRDATA <= DATA_W'(ist_q);
			end else if (PADDR == OFF_IRQ_EN) begin
				PRDATA <= DATA_W'(ien_q);
			end else if (PADDR == OFF_ACTIVE) begin
				PRDATA <= DATA_W'(cause_act);
			end else begin
				PRDATA <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// reset cause status
	// ----------------------------------------------------------------
	// power-on wins over everything; otherwise live causes win over a write
	always_comb begin
		if (cause_act[B_POWER_ON]) begin
			cause_d = CAUSE_POWER_ON_VAL;
		end else begin
			cause_d = wr_cause ? wr_val : cause_q;
			cause_d = cause_d | REG_W'(cause_act);
		end
	end

	// flags survive every reset but power-on and SYS_RST
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			cause_q <= CAUSE_POWER_ON_VAL;
		end else if (CLK_EN) begin
			cause_q <= cause_d;
		end
	end

	// ----------------------------------------------------------------
	// oscillator control
	// ----------------------------------------------------------------
	// any reset cause reloads the new oscillator field from configuration; SYS_RST clears it
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			osc_q <= OSC_RST_VAL;
		end else if (CLK_EN) begin
			if (any_cause) begin
				osc_q <= OSC_RST_VAL;
				osc_q[NEW_OSCILLATOR_FIELD_LSB +: NEW_OSCILLATOR_FIELD_W] <= BOOT_OSCILLATOR_CHOICE;
			end else if (wr_acc && PADDR == OFF_OSC) begin
				osc_q <= wr_val;
			end
		end
	end
	assign NEW_OSCILLATOR_FIELD = osc_q[NEW_OSCILLATOR_FIELD_LSB +: NEW_OSCILLATOR_FIELD_W];

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	// enables return to off on any reset
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			ien_q <= IRQ_EN_RST_VAL;
		end else if (CLK_EN) begin
			if (any_cause) begin
				ien_q <= IRQ_EN_RST_VAL;
			end else if (wr_acc && PADDR == OFF_IRQ_EN) begin
				ien_q <= PWDATA[NCAUSE-1:0];
			end
		end
	end

	// sticky cause-onset events, write one to clear, a new event wins
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			ist_q <= '0;
		end else if (CLK_EN) begin
			if (wr_acc && PADDR == OFF_IRQ_CLR) begin
				ist_q <= (ist_q & ~PWDATA[NCAUSE-1:0]) | cause_rise;
			end else begin
				ist_q <= ist_q | cause_rise;
			end
		end
	end

	// level interrupt output
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			IRQ <= 1'b0;
		end else if (CLK_EN) begin
			IRQ <= |(ist_q & ien_q);
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);

	property p_master_on;
		CLK_EN && any_cause |=> MASTER_RESET_SIGNAL;
	endproperty
	a_master_on: assert property (p_master_on) else $error("master reset missed a cause");

	property p_no_sw_reset;
		CLK_EN && !any_cause && wr_cause |=> !MASTER_RESET_SIGNAL;
	endproperty
	a_no_sw_reset: assert property (p_no_sw_reset) else $error("flag write caused reset");

	property p_por_flags;
		CLK_EN && cause_act[B_POWER_ON] |=> cause_q == CAUSE_POWER_ON_VAL;
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("power-on flag pattern wrong");

	property p_wdt_flag;
		CLK_EN && !cause_act[B_POWER_ON] && cause_act[B_WATCHDOG] |=> cause_q[B_WATCHDOG];
	endproperty
	a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

	property p_keep_flags;
		CLK_EN && !cause_act[B_POWER_ON] && !wr_cause
			|=> (cause_q & $past(cause_q)) == $past(cause_q);
	endproperty
	a_keep_flags: assert property (p_keep_flags) else $error("cause flag lost");

	property p_sw_write;
		CLK_EN && wr_cause && !any_cause |=> cause_q == $past(wr_val);
	endproperty
	a_sw_write: assert property (p_sw_write) else $error("flag write not taken");

	property p_osc_load;
		CLK_EN && any_cause |=> NEW_OSCILLATOR_FIELD == $past(BOOT_OSCILLATOR_CHOICE);
	endproperty
	a_osc_load: assert property (p_osc_load) else $error("oscillator field not loaded");

	property p_irq_raise;
		CLK_EN ##1 (CLK_EN && |(ist_q & ien_q)) |=> IRQ;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

	property p_freeze;
		!CLK_EN |=> $stable(cause_q) && $stable(osc_q) && $stable(ist_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	// a cause seen in the same cycle as a flag write survives the write
	property p_set_wins;
		CLK_EN && wr_cause && !cause_act[B_POWER_ON]
			|=> cause_q == ($past(wr_val) | REG_W'($past(cause_act)));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("cause lost to flag write");

	property p_ist_set;
		CLK_EN && (|cause_rise) |=> (ist_q & $past(cause_rise)) == $past(cause_rise);
	endproperty
	a_ist_set: assert property (p_ist_set) else $error("event lost in status");

	// main scenarios: power-on, watchdog event, software clear, frozen cause
	c_por: cover property (CLK_EN && cause_act[B_POWER_ON] ##1 !any_cause);
	c_freeze: cover property (!CLK_EN && any_cause);
	c_wdt: cover property (CLK_EN && cause_rise[B_WATCHDOG] ##[1:8] IRQ);
	c_flag_clear: cover property (wr_cause && wr_val == '0 && !any_cause);
endmodule
`default_nettype wire

//--- tb/src_cause_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// reset source model: pins, watchdog and cpu cause lines
// ----------------------------------------------------------------
module src_cause_model (
	input wire logic [9:0] req,
	output logic [9:0] line
);
	// cause levels follow the bench request; clear pin idles high (active low)
	assign line = req ^ 10'h004;
endmodule
`default_nettype wire

//--- tb/src_reset_combiner_test.sv
`timescale 1ns/1ps
`default_nettype none
module src_reset_combiner_test;
	import src_pkg::*;
	logic clk, rst, ce, psel, pen, pwr, pslverr, pready, mr, irq, serr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd, exp;
	logic [NEW_OSCILLATOR_FIELD_W-1:0] boot, nof;
	logic [9:0] req, line;
	int err_count, checked;
	// ----------------------------------------------------------------
	// clock, source model and design
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	src_cause_model i_src_cause_model (.req(req), .line(line));
	src_reset_combiner i_src_reset_combiner (.CLOCK(clk), .SYS_RST(rst), .CLK_EN(ce),
		.POWER_ON_RESET(line[0]), .BROWN_OUT_RESET(line[1]),
		.EXTERNAL_CLEAR_PIN_RESET_N(line[2]), .RESET_INSTRUCTION_CAUSE(line[3]),
		.WATCHDOG_TIMEOUT_RESET(line[4]), .CONFIGURATION_MISMATCH_RESET(line[5]),
		.TRAP_CONFLICT_RESET(line[6]), .ILLEGAL_OPCODE_RESET(line[7]),
		.UNINIT_WREG_RESET(line[8]), .SECURITY_RESET(line[9]),
		.BOOT_OSCILLATOR_CHOICE(boot), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .MASTER_RESET_SIGNAL(mr), .NEW_OSCILLATOR_FIELD(nof),
		.IRQ(irq));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
		checked++;
		if (got !== want) begin
			err_count++;
			$display("[ERR] %0t %s: got %h want %h", $time, what, got, want);
		end
	endtask
	// one apb transfer; holds the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] want, input string what);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, want, what);
	endtask
	task automatic irqchk(input logic want, input string what);
		@(posedge clk);
		#1 chk(32'(irq), 32'(want), what);
	endtask
	// raise one cause for hold cycles, watch the master reset rise and fall
	task automatic fire(input int b, input int hold, input logic [NEW_OSCILLATOR_FIELD_W-1:0] bv);
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		req <= 10'h001 << b;
		boot <= bv;
		for (int i = 0; i < hold + 4; i++) begin
			@(posedge clk);
			if (i == hold - 1) req <= 10'h000;
			#1 seen = seen | mr;
		end
		chk(32'(seen), 32'h0000_0001, "master raised");
		chk(32'(mr), 32'h0000_0000, "master released");
		chk(32'(nof), 32'(bv), "new osc field");
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// watchdog and test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_of_test();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = '0;
		pwdata = '0;
		req = '0;
		boot = '0;
		err_count = 0;
		checked = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1 chk(32'(mr), 32'h0000_0001, "master in reset");
		rdchk(OFF_CAUSE, 32'h0000_0003, "cause after reset");
		$display("test reset done");
		apb(1'b1, OFF_CAUSE, 32'h0000_03FF);
		@(posedge clk);
		#1 chk(32'(mr), 32'h0000_0000, "no reset from write");
		rdchk(OFF_CAUSE, 32'h0000_03FF, "flags set");
		apb(1'b1, OFF_CAUSE, 32'h0000_0000);
		rdchk(OFF_CAUSE, 32'h0000_0000, "flags cleared");
		apb(1'b1, OFF_OSC, 32'h0000_0012);
		rdchk(OFF_OSC, 32'h0000_0012, "osc written");
		$display("test software flags done");
		exp = '0;
		for (int b = 1; b < NCAUSE; b++) begin
			fire(b, (b < NPIN) ? 4 : 1, NEW_OSCILLATOR_FIELD_W'((b + 1) % 8));
			exp[b] = 1'b1;
			rdchk(OFF_CAUSE, exp, "cause flags");
			rdchk(OFF_OSC, 32'((b + 1) % 8) << NEW_OSCILLATOR_FIELD_LSB, "osc reload");
		end
		fire(0, 4, 3'h5);
		rdchk(OFF_CAUSE, 32'h0000_0003, "power on flags");
		rdchk(OFF_OSC, 32'h0000_0500, "osc after power on");
		$display("test causes done");
		rdchk(OFF_IRQ_STAT, 32'h0000_03FF, "irq status");
		chk(32'(irq), 32'h0000_0000, "irq disabled");
		apb(1'b1, OFF_IRQ_EN, 32'h0000_0010);
		irqchk(1'b1, "irq enabled");
		apb(1'b1, OFF_IRQ_EN, 32'h0000_0000);
		irqchk(1'b0, "irq masked");
		apb(1'b1, OFF_IRQ_EN, 32'h0000_0010);
		apb(1'b1, OFF_IRQ_CLR, 32'h0000_0010);
		irqchk(1'b0, "irq cleared");
		apb(1'b1, OFF_IRQ_STAT, 32'h0000_0000);
		rdchk(OFF_IRQ_STAT, 32'h0000_03EF, "status read only");
		rdchk(OFF_IRQ_CLR, 32'h0000_0000, "clear reads zero");
		rdchk(OFF_ACTIVE, 32'h0000_0000, "no live causes");
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk(32'(serr), 32'h0000_0001, "unmapped error");
		chk(rd, 32'h0000_0000, "unmapped data");
		$display("test interrupts and bus done");
		apb(1'b1, OFF_IRQ_EN, 32'h0000_0010);
		@(posedge clk);
		ce <= 1'b0;
		req <= 10'h010;
		repeat (3) @(posedge clk);
		#1 chk(32'(mr), 32'h0000_0000, "frozen master");
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		req <= 10'h000;
		#1 chk(32'(mr), 32'h0000_0001, "master after thaw");
		rdchk(OFF_IRQ_EN, 32'h0000_0000, "enables reset");
		rdchk(OFF_CAUSE, 32'h0000_0013, "watchdog flag added");
		$display("test clock enable done");
		end_of_test();
	end
endmodule
`default_nettype wire
